//--- cmc_pkg.sv
// Constants shared by the converter mode control block.
// Assumes a single core clock domain; pins are synchronised in the top module.
package cmc_pkg;
  localparam int unsigned DATA_W        = 12;
  localparam int unsigned RAW_W         = 14;
  localparam int unsigned GAIN_W        = 15;
  localparam int unsigned OFFS_W        = 13;
  localparam int unsigned GAIN_FRAC     = 14;
  localparam int unsigned REG_N         = 16;
  localparam int unsigned REG_W         = 16;
  localparam int unsigned CNT_W         = 16;
  localparam int unsigned GAP_W         = 8;

  localparam logic [3:0]  ADDR_SETUP    = 4'h0;
  localparam logic [3:0]  ADDR_I_GAIN   = 4'h1;
  localparam logic [3:0]  ADDR_I_OFFS   = 4'h2;
  localparam logic [3:0]  ADDR_Q_GAIN   = 4'h9;
  localparam logic [3:0]  ADDR_Q_OFFS   = 4'hA;
  localparam logic [3:0]  ADDR_STATUS   = 4'hF;

  localparam int unsigned BIT_CAL       = 15;
  localparam int unsigned BIT_PHASE     = 14;
  localparam int unsigned BIT_I_SLEEP   = 11;
  localparam int unsigned BIT_Q_SLEEP   = 10;
  localparam int unsigned BIT_ILV       = 7;
  localparam int unsigned BIT_Q_SEL     = 6;
  localparam int unsigned BIT_BOTH      = 5;

  localparam int unsigned ST_CAL_BUSY   = 0;
  localparam int unsigned ST_EXT_MODE   = 1;
  localparam int unsigned ST_ILV        = 2;
  localparam int unsigned ST_DEMUX      = 3;
  localparam int unsigned ST_I_OVR      = 4;
  localparam int unsigned ST_Q_OVR      = 5;

  localparam logic [15:0] SETUP_RST     = 16'h0000;
  localparam logic [15:0] GAIN_RST      = 16'h4000;
  localparam logic [15:0] OFFS_RST      = 16'h0000;
  localparam logic [11:0] CODE_MAX      = 12'hFFF;
  localparam logic [11:0] CODE_MIN      = 12'h000;

  localparam int unsigned CORE_CLK_MHZ  = 200;
  localparam int unsigned CAL_RUN_NS    = 1000;
  localparam int unsigned CAL_RUN_CYC   = (CAL_RUN_NS * CORE_CLK_MHZ + 999) / 1000;
  localparam int unsigned CAL_LOW_MIN   = 4;
  localparam int unsigned CAL_HIGH_MIN  = 4;
  localparam int unsigned STRAP_WAIT    = 3;

  typedef enum logic [1:0] {CAL_POR_WAIT, CAL_IDLE, CAL_RUN} cmc_cal_state_t;
endpackage

//--- cmc_chan_cfg_if.sv
// Per-channel configuration bundle from the control logic to a lane packer.
// Assumes the driver holds every field stable on the core clock.
`timescale 1ns/1ps
interface cmc_chan_cfg_if;
  logic [cmc_pkg::GAIN_W-1:0] gain;
  logic [cmc_pkg::OFFS_W-1:0] offset;
  logic                       demux;
  logic                       phase90;
  logic                       sleep;
  modport ctl  (output gain, output offset, output demux, output phase90, output sleep);
  modport chan (input gain, input offset, input demux, input phase90, input sleep);
endinterface

//--- cmc_lane_packer.sv
// One channel: gain/offset, clamp, over-range, demux onto two buses, DDR clock.
// Assumes sample_stb is a one-cycle pulse spaced at least four core cycles apart.
`timescale 1ns/1ps
module cmc_lane_packer (
  input  wire logic                              clk,
  input  wire logic                              rst_n,
  cmc_chan_cfg_if.chan                           cfg,
  input  wire logic                              sample_stb,
  input  wire logic signed [cmc_pkg::RAW_W-1:0]  sample_raw,
  output wire logic [cmc_pkg::DATA_W-1:0]        bus_a,
  output wire logic [cmc_pkg::DATA_W-1:0]        bus_b,
  output wire logic                              oe_a,
  output wire logic                              oe_b,
  output wire logic                              output_data_clock,
  output wire logic                              ovr
);
  localparam int unsigned PROD_W = cmc_pkg::RAW_W + cmc_pkg::GAIN_W + 1;
  localparam int unsigned SUM_W  = PROD_W - cmc_pkg::GAIN_FRAC + 1;

  logic [cmc_pkg::DATA_W-1:0] bus_a_reg, bus_b_reg, hold_reg;
  logic                       hold_ovr_reg, half_reg, ovr_reg, output_data_clock_reg, pend_reg, oe_a_reg, oe_b_reg;
  logic [cmc_pkg::GAP_W-1:0]  gap_cnt_reg, last_gap_reg;

  wire logic signed [PROD_W-1:0] prod      = sample_raw * $signed({1'b0, cfg.gain});
  wire logic signed [SUM_W-2:0]  scaled    = prod[PROD_W-1:cmc_pkg::GAIN_FRAC];
  wire logic signed [SUM_W-1:0]  offs_mag  = {{(SUM_W-cmc_pkg::OFFS_W+1){1'b0}}, cfg.offset[cmc_pkg::OFFS_W-2:0]};
  wire logic signed [SUM_W-1:0]  offs_val  = cfg.offset[cmc_pkg::OFFS_W-1] ? -offs_mag : offs_mag;
  wire logic signed [SUM_W-1:0]  sum       = {scaled[SUM_W-2], scaled} + offs_val;
  // Clamp ends: below zero reads all zeros, above range all ones
  wire logic                     under     = sum[SUM_W-1];
  wire logic                     over      = !sum[SUM_W-1] && (sum[SUM_W-2:cmc_pkg::DATA_W] != '0);
  wire logic [cmc_pkg::DATA_W-1:0] word    = under ? cmc_pkg::CODE_MIN :
                                             over  ? cmc_pkg::CODE_MAX : sum[cmc_pkg::DATA_W-1:0];
  wire logic                     ovr_now   = under || over;
  // Demux emits every second sample, so each bus runs at half rate
  wire logic                     emit      = sample_stb && (!cfg.demux || half_reg);
  wire logic [cmc_pkg::GAP_W-1:0] half_gap = (last_gap_reg > 8'h03) ? (last_gap_reg >> 1) : 8'h01;
  wire logic                     toggle90  = pend_reg && !emit && (gap_cnt_reg >= half_gap);
  wire logic                     tog       = cfg.phase90 ? toggle90 : emit;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bus_a_reg    <= '0;
      bus_b_reg    <= '0;
      hold_reg     <= '0;
      hold_ovr_reg <= 1'b0;
      half_reg     <= 1'b0;
      ovr_reg      <= 1'b0;
    end else begin
      if (sample_stb) begin
        half_reg <= cfg.demux && !half_reg;
      end
      if (sample_stb && cfg.demux && !half_reg) begin
        hold_reg     <= word;
        hold_ovr_reg <= ovr_now;
      end
      if (emit) begin
        bus_a_reg <= cfg.demux ? hold_reg : word;
        bus_b_reg <= cfg.demux ? word : bus_b_reg;
        // Flag leaves with its word, same latency
        ovr_reg   <= ovr_now || (cfg.demux && hold_ovr_reg);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      output_data_clock_reg     <= 1'b0;
      pend_reg     <= 1'b0;
      gap_cnt_reg  <= '0;
      last_gap_reg <= '0;
      oe_a_reg     <= 1'b0;
      oe_b_reg     <= 1'b0;
    end else begin
      output_data_clock_reg     <= output_data_clock_reg ^ tog;
      // Set wins over clear so a back-to-back word never loses its edge
      pend_reg     <= (emit && cfg.phase90) || (pend_reg && !toggle90);
      gap_cnt_reg  <= emit ? '0 : ((gap_cnt_reg == '1) ? gap_cnt_reg : gap_cnt_reg + 8'h01);
      last_gap_reg <= emit ? gap_cnt_reg : last_gap_reg;
      oe_a_reg     <= !cfg.sleep;
      oe_b_reg     <= !cfg.sleep && cfg.demux;
    end
  end

  assign bus_a = bus_a_reg;
  assign bus_b = bus_b_reg;
  assign oe_a  = oe_a_reg;
  assign oe_b  = oe_b_reg;
  assign output_data_clock  = output_data_clock_reg;
  assign ovr   = ovr_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_clamp_high;
    sample_stb && over && !cfg.demux |=> bus_a == cmc_pkg::CODE_MAX;
  endproperty
  a_clamp_high: assert property (p_clamp_high) else $error("over-range word not all ones");
  property p_clamp_low;
    sample_stb && under && !cfg.demux |=> bus_a == cmc_pkg::CODE_MIN;
  endproperty
  a_clamp_low: assert property (p_clamp_low) else $error("under-range word not all zeros");
  property p_ovr_aligned;
    emit && ovr_now |=> ovr && $changed(bus_a) || ovr;
  endproperty
  a_ovr_aligned: assert property (p_ovr_aligned) else $error("over-range flag missing with word");
  property p_zero_phase;
    emit && !cfg.phase90 |=> output_data_clock != $past(output_data_clock);
  endproperty
  a_zero_phase: assert property (p_zero_phase) else $error("0 degree clock not edge aligned");
  property p_sleep_hiz;
    cfg.sleep |=> !oe_a && !oe_b;
  endproperty
  a_sleep_hiz: assert property (p_sleep_hiz) else $error("sleeping channel still drives");
  property p_one_bus;
    !cfg.demux |=> !oe_b;
  endproperty
  a_one_bus: assert property (p_one_bus) else $error("second bus active in non-demux");

  c_demux_emit: cover property (emit && cfg.demux);
  c_phase90: cover property (toggle90 && cfg.phase90);
endmodule

//--- cmc_converter_mode_control.sv
// Top of the converter mode control: pin sync, sixteen-register file, mode select,
// calibration sequencing and two channel lane packers.
// Assumes the register port is on CORE_CLK and pins are asynchronous to it.
`timescale 1ns/1ps
// Function
// - Every output word is twelve bits wide
// - Input below range gives all-zero word
// - Input above range gives all-ones word
// - Either range fault raises channel over-range flag
// - Demux halves bus rate; non-demux uses one bus
// - Extended mode: per-channel gain and signed offset
// - Enable pin high: pin control, port inactive
// - Extended mode exposes fifteen host-configured registers and a read-only status register
// - Interleave: one converter rising, other falling edge
// - Pin mode uses I; extended selects Q or both
// - Extended mode interleave enable from setup bit 7
// - Single-bus pin selects demux, both control modes
// - Interleave doubles buses driven by selected channel
// - DDR data at 0 or 90 degree phase
// - Phase shared by channels; bit 14 in extended
// - Calibration pin high at power-on skips calibration
// - Extended mode: calibration is pin OR bit 15
// - Enable pin high returns registers to defaults
// - Sleeping channel releases its data buses
module cmc_converter_mode_control #(
  parameter int unsigned CAL_LOW_MIN  = cmc_pkg::CAL_LOW_MIN,
  parameter int unsigned CAL_HIGH_MIN = cmc_pkg::CAL_HIGH_MIN,
  parameter int unsigned CAL_RUN_CYC  = cmc_pkg::CAL_RUN_CYC
) (
  input  wire logic                          CORE_CLK,
  input  wire logic                          RESETN,
  input  wire logic                          SAMPLE_CLK,
  input  wire logic [cmc_pkg::RAW_W-1:0]     I_ANALOG_CODE,
  input  wire logic [cmc_pkg::RAW_W-1:0]     Q_ANALOG_CODE,
  input  wire logic                          EXTENDED_CONTROL_ENABLE_N,
  input  wire logic                          INTERLEAVE_PIN,
  input  wire logic                          SINGLE_BUS_MODE_PIN,
  input  wire logic                          DDR_PHASE_PIN,
  input  wire logic                          CAL_PIN,
  input  wire logic                          I_CHANNEL_SLEEP_PIN,
  input  wire logic                          Q_CHANNEL_SLEEP_PIN,
  input  wire logic                          REG_WE,
  input  wire logic [3:0]                    REG_ADDR,
  input  wire logic [cmc_pkg::REG_W-1:0]     REG_WDATA,
  output wire logic [cmc_pkg::REG_W-1:0]     REG_RDATA,
  output wire logic [cmc_pkg::DATA_W-1:0]    I_BUS_A,
  output wire logic                          I_BUS_A_OE,
  output wire logic [cmc_pkg::DATA_W-1:0]    I_BUS_B,
  output wire logic                          I_BUS_B_OE,
  output wire logic [cmc_pkg::DATA_W-1:0]    Q_BUS_A,
  output wire logic                          Q_BUS_A_OE,
  output wire logic [cmc_pkg::DATA_W-1:0]    Q_BUS_B,
  output wire logic                          Q_BUS_B_OE,
  output wire logic                          OUTPUT_DATA_CLOCK_I,
  output wire logic                          OUTPUT_DATA_CLOCK_Q,
  output wire logic                          I_OVERRANGE_FLAG,
  output wire logic                          Q_OVERRANGE_FLAG,
  output wire logic                          CAL_BUSY
);
  localparam int unsigned SYNC_W = 8 + 2 * cmc_pkg::RAW_W;
  // Enable pin synchronises as high so reset starts in pin control
  localparam logic [SYNC_W-1:0] SYNC_RST = {1'b0, 1'b1, {(SYNC_W-2){1'b0}}};

  function automatic logic [cmc_pkg::REG_W-1:0] reg_default(input logic [3:0] addr);
    logic [cmc_pkg::REG_W-1:0] val;
    val = cmc_pkg::SETUP_RST;
    if (addr == cmc_pkg::ADDR_I_GAIN || addr == cmc_pkg::ADDR_Q_GAIN) begin
      val = cmc_pkg::GAIN_RST;
    end else if (addr == cmc_pkg::ADDR_I_OFFS || addr == cmc_pkg::ADDR_Q_OFFS) begin
      val = cmc_pkg::OFFS_RST;
    end
    return val;
  endfunction

  // Two-flop synchroniser; the codes are assumed stable around the sample edge
  logic [SYNC_W-1:0] pin_meta_reg, pin_sync_reg;
  wire logic [SYNC_W-1:0] pin_in = {SAMPLE_CLK, EXTENDED_CONTROL_ENABLE_N, INTERLEAVE_PIN, SINGLE_BUS_MODE_PIN,
                                     DDR_PHASE_PIN, CAL_PIN, I_CHANNEL_SLEEP_PIN, Q_CHANNEL_SLEEP_PIN,
                                     I_ANALOG_CODE, Q_ANALOG_CODE};
  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      pin_meta_reg <= SYNC_RST;
      pin_sync_reg <= SYNC_RST;
    end else begin
      pin_meta_reg <= pin_in;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  wire logic                     sclk_s   = pin_sync_reg[SYNC_W-1];
  wire logic                     ece_n_s  = pin_sync_reg[SYNC_W-2];
  wire logic                     ilv_s    = pin_sync_reg[SYNC_W-3];
  wire logic                     ndm_s    = pin_sync_reg[SYNC_W-4];
  wire logic                     phase_s  = pin_sync_reg[SYNC_W-5];
  wire logic                     cal_s    = pin_sync_reg[SYNC_W-6];
  wire logic                     isl_s    = pin_sync_reg[SYNC_W-7];
  wire logic                     qsl_s    = pin_sync_reg[SYNC_W-8];
  wire logic [cmc_pkg::RAW_W-1:0] i_code_s = pin_sync_reg[2*cmc_pkg::RAW_W-1:cmc_pkg::RAW_W];
  wire logic [cmc_pkg::RAW_W-1:0] q_code_s = pin_sync_reg[cmc_pkg::RAW_W-1:0];

  logic sclk_prev_reg;
  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      sclk_prev_reg <= 1'b0;
    end else begin
      sclk_prev_reg <= sclk_s;
    end
  end
  wire logic rise = sclk_s && !sclk_prev_reg;
  wire logic fall = !sclk_s && sclk_prev_reg;

  wire logic extended_control_mode = !ece_n_s;

  // Register file; pin control holds every register at its default
  logic [cmc_pkg::REG_W-1:0] regs_reg [cmc_pkg::REG_N];
  genvar g;
  generate
    for (g = 0; g < cmc_pkg::REG_N; g++) begin : g_reg
      always_ff @(posedge CORE_CLK) begin
        if (!RESETN || !extended_control_mode) begin
          regs_reg[g] <= reg_default(4'(g));
        end else if (REG_WE && REG_ADDR == 4'(g) && 4'(g) != cmc_pkg::ADDR_STATUS) begin
          regs_reg[g] <= REG_WDATA;
        end
      end
    end
  endgenerate

  wire logic [cmc_pkg::REG_W-1:0] setup = regs_reg[cmc_pkg::ADDR_SETUP];

  // Mode selection
  wire logic ilv     = extended_control_mode ? setup[cmc_pkg::BIT_ILV] : ilv_s;
  wire logic both_in = extended_control_mode && setup[cmc_pkg::BIT_BOTH];
  wire logic q_sel   = extended_control_mode && setup[cmc_pkg::BIT_Q_SEL] && !both_in;
  wire logic demux   = !ndm_s;
  wire logic phase90 = extended_control_mode ? setup[cmc_pkg::BIT_PHASE] : phase_s;
  wire logic i_sleep = isl_s || (extended_control_mode && setup[cmc_pkg::BIT_I_SLEEP]);
  wire logic q_sleep = qsl_s || (extended_control_mode && setup[cmc_pkg::BIT_Q_SLEEP]);

  // Interleave: I converter on rising edge, Q converter on falling edge, same input unless setup bit 5 selects both inputs
  wire logic                     i_stb = rise;
  wire logic                     q_stb = ilv ? fall : rise;
  wire logic [cmc_pkg::RAW_W-1:0] i_raw = (ilv && q_sel) ? q_code_s : i_code_s;
  wire logic [cmc_pkg::RAW_W-1:0] q_raw = (ilv && !q_sel && !both_in) ? i_code_s : q_code_s;

  // Calibration sequencing; command low/high periods in sampling clock cycles, run length in core cycles
  wire logic cal_req = cal_s || (extended_control_mode && setup[cmc_pkg::BIT_CAL]);
  cmc_pkg::cmc_cal_state_t state_reg, state_next;
  logic [cmc_pkg::CNT_W-1:0] low_cnt_reg, high_cnt_reg, run_cnt_reg, por_cnt_reg;
  wire logic low_ok    = low_cnt_reg >= cmc_pkg::CNT_W'(CAL_LOW_MIN);
  wire logic cmd_start = rise && cal_req && low_ok && (high_cnt_reg >= cmc_pkg::CNT_W'(CAL_HIGH_MIN - 1));
  wire logic por_done  = por_cnt_reg >= cmc_pkg::CNT_W'(cmc_pkg::STRAP_WAIT);
  wire logic run_done  = run_cnt_reg >= cmc_pkg::CNT_W'(CAL_RUN_CYC - 1);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      // Strap is read only once the synchroniser holds the real pin level
      cmc_pkg::CAL_POR_WAIT: state_next = !por_done ? cmc_pkg::CAL_POR_WAIT :
                                          (cal_s ? cmc_pkg::CAL_IDLE : cmc_pkg::CAL_RUN);
      cmc_pkg::CAL_IDLE:     state_next = cmd_start ? cmc_pkg::CAL_RUN : cmc_pkg::CAL_IDLE;
      cmc_pkg::CAL_RUN:      state_next = run_done ? cmc_pkg::CAL_IDLE : cmc_pkg::CAL_RUN;
      default:               state_next = cmc_pkg::CAL_IDLE;
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      state_reg    <= cmc_pkg::CAL_POR_WAIT;
      por_cnt_reg  <= '0;
      run_cnt_reg  <= '0;
      low_cnt_reg  <= '0;
      high_cnt_reg <= '0;
    end else begin
      state_reg    <= state_next;
      por_cnt_reg  <= por_done ? por_cnt_reg : por_cnt_reg + 16'h0001;
      run_cnt_reg  <= (state_reg == cmc_pkg::CAL_RUN) ? run_cnt_reg + 16'h0001 : '0;
      // A new command needs a fresh low period; requests during a run are dropped
      if (cmd_start) begin
        low_cnt_reg  <= '0;
        high_cnt_reg <= '0;
      end else if (rise && !cal_req) begin
        low_cnt_reg  <= low_ok ? low_cnt_reg : low_cnt_reg + 16'h0001;
        high_cnt_reg <= '0;
      end else if (rise && low_ok) begin
        high_cnt_reg <= high_cnt_reg + 16'h0001;
      end
    end
  end

  // Channel configuration and packers
  cmc_chan_cfg_if i_cfg ();
  cmc_chan_cfg_if q_cfg ();
  assign i_cfg.gain    = regs_reg[cmc_pkg::ADDR_I_GAIN][cmc_pkg::GAIN_W-1:0];
  assign i_cfg.offset  = regs_reg[cmc_pkg::ADDR_I_OFFS][cmc_pkg::OFFS_W-1:0];
  assign i_cfg.demux   = demux;
  assign i_cfg.phase90 = phase90;
  assign i_cfg.sleep   = i_sleep;
  assign q_cfg.gain    = regs_reg[cmc_pkg::ADDR_Q_GAIN][cmc_pkg::GAIN_W-1:0];
  assign q_cfg.offset  = regs_reg[cmc_pkg::ADDR_Q_OFFS][cmc_pkg::OFFS_W-1:0];
  assign q_cfg.demux   = demux;
  assign q_cfg.phase90 = phase90;
  assign q_cfg.sleep   = q_sleep;

  cmc_lane_packer u_i_lane (
    .clk        (CORE_CLK),
    .rst_n      (RESETN),
    .cfg        (i_cfg),
    .sample_stb (i_stb),
    .sample_raw ($signed(i_raw)),
    .bus_a      (I_BUS_A),
    .bus_b      (I_BUS_B),
    .oe_a       (I_BUS_A_OE),
    .oe_b       (I_BUS_B_OE),
    .output_data_clock       (OUTPUT_DATA_CLOCK_I),
    .ovr        (I_OVERRANGE_FLAG)
  );
  cmc_lane_packer u_q_lane (
    .clk        (CORE_CLK),
    .rst_n      (RESETN),
    .cfg        (q_cfg),
    .sample_stb (q_stb),
    .sample_raw ($signed(q_raw)),
    .bus_a      (Q_BUS_A),
    .bus_b      (Q_BUS_B),
    .oe_a       (Q_BUS_A_OE),
    .oe_b       (Q_BUS_B_OE),
    .output_data_clock       (OUTPUT_DATA_CLOCK_Q),
    .ovr        (Q_OVERRANGE_FLAG)
  );

  // Read-back; the serial side is silent in pin control
  wire logic [cmc_pkg::REG_W-1:0] status = {10'h000, Q_OVERRANGE_FLAG, I_OVERRANGE_FLAG, demux, ilv, extended_control_mode,
                                            CAL_BUSY};
  wire logic [cmc_pkg::REG_W-1:0] rd_sel = !extended_control_mode ? 16'h0000 :
                                           (REG_ADDR == cmc_pkg::ADDR_STATUS) ? status : regs_reg[REG_ADDR];
  logic [cmc_pkg::REG_W-1:0] rdata_reg;
  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= rd_sel;
    end
  end
  assign REG_RDATA = rdata_reg;
  assign CAL_BUSY  = (state_reg == cmc_pkg::CAL_RUN);

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESETN);

  property p_pin_defaults;
    !extended_control_mode |=> regs_reg[cmc_pkg::ADDR_SETUP] == cmc_pkg::SETUP_RST && regs_reg[cmc_pkg::ADDR_I_GAIN] == cmc_pkg::GAIN_RST;
  endproperty
  a_pin_defaults: assert property (p_pin_defaults) else $error("registers not at default in pin mode");
  property p_port_silent;
    !extended_control_mode |=> REG_RDATA == 16'h0000;
  endproperty
  a_port_silent: assert property (p_port_silent) else $error("serial read data active in pin mode");
  property p_cal_start;
    state_reg == cmc_pkg::CAL_IDLE && cmd_start |=> CAL_BUSY [*8];
  endproperty
  a_cal_start: assert property (p_cal_start) else $error("command calibration did not run");
  property p_strap_skip;
    state_reg == cmc_pkg::CAL_POR_WAIT && por_done && cal_s |=> !CAL_BUSY ##1 !CAL_BUSY;
  endproperty
  a_strap_skip: assert property (p_strap_skip) else $error("power-on calibration not skipped");
  property p_ilv_edges;
    ilv && fall |-> q_stb && !i_stb;
  endproperty
  a_ilv_edges: assert property (p_ilv_edges) else $error("interleave falling edge not on Q converter");
  property p_cal_or;
    extended_control_mode && setup[cmc_pkg::BIT_CAL] && !cal_s |-> cal_req;
  endproperty
  a_cal_or: assert property (p_cal_or) else $error("calibration bit not merged with pin");
  property p_demux_pin;
    ndm_s |=> !I_BUS_B_OE && !Q_BUS_B_OE;
  endproperty
  a_demux_pin: assert property (p_demux_pin) else $error("second bus driven in non-demux");
  property p_phase_shared;
    extended_control_mode |-> i_cfg.phase90 == setup[cmc_pkg::BIT_PHASE] && q_cfg.phase90 == i_cfg.phase90;
  endproperty
  a_phase_shared: assert property (p_phase_shared) else $error("phase select not shared from setup");
  property p_pin_ilv;
    !extended_control_mode && ilv_s |-> q_stb == fall && i_raw == i_code_s && q_raw == i_code_s;
  endproperty
  a_pin_ilv: assert property (p_pin_ilv) else $error("pin interleave not on I input");
  property p_ext_ilv;
    extended_control_mode |-> ilv == setup[cmc_pkg::BIT_ILV];
  endproperty
  a_ext_ilv: assert property (p_ext_ilv) else $error("interleave not taken from setup bit");
  property p_cal_len;
    $fell(CAL_BUSY) |-> $past(run_cnt_reg) == cmc_pkg::CNT_W'(CAL_RUN_CYC - 1);
  endproperty
  a_cal_len: assert property (p_cal_len) else $error("calibration run length wrong");
  property p_sleep_pin;
    isl_s |=> !I_BUS_A_OE && !I_BUS_B_OE;
  endproperty
  a_sleep_pin: assert property (p_sleep_pin) else $error("sleep pin did not release I buses");

  c_cmd_cal: cover property (cmd_start);
  c_ilv_run: cover property (ilv && demux && fall);
  c_ext_mode: cover property (extended_control_mode && REG_WE);
endmodule

//--- cmc_capture_model.sv
// Capture logic on the far side of one DDR sample bus.
// Assumes the core clock is fast enough to see every data clock toggle.
`timescale 1ns/1ps
module cmc_capture_model (
  input  wire logic                        clk,
  input  wire logic                        output_data_clock,
  input  wire logic [cmc_pkg::DATA_W-1:0]  bus,
  output logic      [cmc_pkg::DATA_W-1:0]  word,
  output int                               words
);
  logic output_data_clock_q;
  // Sample one edge after the toggle, past the data change
  always @(posedge clk) begin
    output_data_clock_q <= output_data_clock;
    if (output_data_clock !== output_data_clock_q) begin
      word  <= bus;
      words <= words + 1;
    end
  end
endmodule

//--- cmc_converter_mode_control_tb_top.sv
// Self-checking bench for the converter mode control.
// Assumes the design files are compiled first.
`timescale 1ns/1ps
module cmc_converter_mode_control_tb_top;
  logic clk = 0, rst_n = 0, smp = 0, ece_n = 1, sbm = 1, cal = 1, i_slp = 0, we = 0;
  logic        ilv_p = 0, ph_p = 0;
  logic [3:0]  addr = 4'h0;
  logic [15:0] wd = 16'h0000, rd;
  logic [13:0] i_code = 14'h0000;
  logic [11:0] ia, ib, qa, qb, iw;
  logic        ia_oe, ib_oe, qa_oe, qb_oe, dck_i, dck_q, i_flg, q_flg, busy;
  int          fails = 0, check_count = 0, nw;
  cmc_converter_mode_control #(.CAL_LOW_MIN(1), .CAL_HIGH_MIN(1), .CAL_RUN_CYC(8)) i_dut (
    .CORE_CLK(clk), .RESETN(rst_n), .SAMPLE_CLK(smp), .I_ANALOG_CODE(i_code),
    .Q_ANALOG_CODE(14'h0000), .EXTENDED_CONTROL_ENABLE_N(ece_n), .INTERLEAVE_PIN(ilv_p),
    .SINGLE_BUS_MODE_PIN(sbm), .DDR_PHASE_PIN(ph_p), .CAL_PIN(cal), .I_CHANNEL_SLEEP_PIN(i_slp),
    .Q_CHANNEL_SLEEP_PIN(1'b0), .REG_WE(we), .REG_ADDR(addr), .REG_WDATA(wd), .REG_RDATA(rd),
    .I_BUS_A(ia), .I_BUS_A_OE(ia_oe), .I_BUS_B(ib), .I_BUS_B_OE(ib_oe), .Q_BUS_A(qa),
    .Q_BUS_A_OE(qa_oe), .Q_BUS_B(qb), .Q_BUS_B_OE(qb_oe), .OUTPUT_DATA_CLOCK_I(dck_i),
    .OUTPUT_DATA_CLOCK_Q(dck_q), .I_OVERRANGE_FLAG(i_flg), .Q_OVERRANGE_FLAG(q_flg), .CAL_BUSY(busy));
  cmc_capture_model i_cap (.clk(clk), .output_data_clock(dck_i), .bus(ia), .word(iw), .words(nw));
  initial forever #2.5 clk = ~clk;
  // Sampling clock free-running, unrelated to the core clock
  initial forever #24 smp = ~smp;
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
    addr = a;
    wd = d;
    we = 1'b1;
    cyc(1);
    we = 1'b0;
  endtask
  task automatic reg_chk(input logic [3:0] a, input logic [15:0] exp);
    addr = a;
    cyc(2);
    chk("reg read", exp, rd);
  endtask
  task automatic wait_busy();
    for (int k = 0; k < 300 && busy !== 1'b1; k++) cyc(1);
    chk("cal busy", 16'h0001, {15'h0000, busy});
    for (int k = 0; k < 300 && busy !== 1'b0; k++) cyc(1);
  endtask
  task automatic t_range();
    logic [13:0] c [3] = '{14'h0123, 14'h1800, 14'h3F00};
    logic [11:0] e [3] = '{12'h123, 12'hFFF, 12'h000};
    for (int k = 0; k < 3; k++) begin
      i_code = c[k];
      repeat (4) @(posedge dck_i);
      cyc(2);
      chk("i word", {4'h0, e[k]}, {4'h0, iw});
      chk("i flag", {15'h0000, k != 0}, {15'h0000, i_flg});
    end
    chk("words", 16'h0001, {15'h0000, nw > 10});
  endtask
  task automatic t_demux();
    i_code = 14'h0ABC;
    sbm = 1'b0;
    repeat (4) @(posedge dck_i);
    cyc(2);
    chk("bus b oe", 16'h0001, {15'h0000, ib_oe});
    chk("bus b", 16'h0ABC, {4'h0, ib});
    chk("bus a", 16'h0ABC, {4'h0, ia});
    sbm = 1'b1;
    i_slp = 1'b1;
    cyc(10);
    chk("bus a oe", 16'h0000, {15'h0000, ia_oe});
    i_slp = 1'b0;
  endtask
  task automatic t_cal_pin();
    chk("strap busy", 16'h0000, {15'h0000, busy});
    reg_chk(4'h0, 16'h0000);
    cal = 1'b0;
    cyc(40);
    cal = 1'b1;
    wait_busy();
  endtask
  task automatic t_ilv();
    ilv_p = 1'b1;
    i_code = 14'h1800;
    repeat (4) @(posedge dck_q);
    cyc(2);
    chk("q word", 16'h0FFF, {4'h0, qa});
    chk("q flag", 16'h0001, {15'h0000, q_flg});
    chk("q oe", 16'h0002, {14'h0000, qa_oe, qb_oe});
    sbm = 1'b0;
    repeat (4) @(posedge dck_q);
    cyc(2);
    chk("q bus b", 16'h0FFF, {4'h0, qb});
    chk("q oe", 16'h0003, {14'h0000, qa_oe, qb_oe});
    sbm = 1'b1;
    ilv_p = 1'b0;
  endtask
  task automatic t_phase();
    logic [11:0] pa;
    logic        pd;
    ph_p = 1'b1;
    i_code = 14'h0555;
    cyc(40);
    i_code = 14'h0AAA;
    pa = ia;
    pd = dck_i;
    for (int k = 0; k < 60 && ia === pa; k++) begin
      pd = dck_i;
      cyc(1);
    end
    chk("i bus 90", 16'h0AAA, {4'h0, ia});
    chk("output_data_clock at word", {15'h0000, pd}, {15'h0000, dck_i});
    cyc(12);
    chk("i word 90", 16'h0AAA, {4'h0, iw});
    ph_p = 1'b0;
  endtask
  task automatic t_ext();
    cal = 1'b0;
    ece_n = 1'b0;
    cyc(24);
    reg_wr(4'h0, 16'h40E0);
    reg_chk(4'h0, 16'h40E0);
    reg_chk(4'hF, 16'h0006);
    reg_wr(4'h0, 16'h8000);
    wait_busy();
    ece_n = 1'b1;
    cyc(6);
    ece_n = 1'b0;
    cyc(6);
    reg_chk(4'h0, 16'h0000);
  endtask
  task automatic finish_test();
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #200us;
    fails++;
    finish_test();
  end
  initial begin
    cyc(16);
    rst_n = 1'b1;
    cyc(30);
    t_cal_pin();
    t_range();
    t_demux();
    t_ilv();
    t_phase();
    t_ext();
    finish_test();
  end
endmodule
